// ==== verilog/bz_pkg.sv ====
// How it works
// - opcode upper byte 0xe0, low byte offset
// - branch taken only when zero flag set
// - pc gets next pc plus twice offset
// - taken branch: two cycles, second is nop
// - q1 decode, q2 literal, q3 compute, q4 write
package bz_pkg;
  localparam logic [7:0] BZ_OPCODE_HI = 8'he0;
  localparam int         PC_WIDTH     = 21;
  localparam logic [1:0] PC_STEP      = 2'h2;
  localparam logic [2:0] NOP_CLOCKS   = 3'h4;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } phase_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } fetch_t;

  typedef struct packed {
    logic                wr;
    logic [PC_WIDTH-1:0] value;
  } pc_write_t;
endpackage

// ==== verilog/phase_gen.sv ====
`timescale 1ns/100ps
module phase_gen
  import bz_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   reset,
  output phase_t      phase
);
  phase_t next_phase;

  always_comb begin
    case (phase)
      PH_Q1:   next_phase = PH_Q2;
      PH_Q2:   next_phase = PH_Q3;
      PH_Q3:   next_phase = PH_Q4;
      PH_Q4:   next_phase = PH_Q1;
      default: next_phase = PH_Q1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase <= PH_Q1;
    end else begin
      phase <= next_phase;
    end
  end
endmodule // phase_gen

// ==== verilog/branch_if_zero_exec.sv ====
`timescale 1ns/100ps
module branch_if_zero_exec
  import bz_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            reset,
  input  wire fetch_t          fetch,
  input  wire logic            zeroFlag,
  input  wire logic [PC_WIDTH-1:0] pcNow,
  output phase_t               phase,
  output pc_write_t            pcWrite,
  output logic                 nopCycle,
  output logic                 busy,
  output logic                 flagsWrite
);
  // ----------------------------------------
  // phase sequencing
  // ----------------------------------------
  phase_gen i_phase_gen (
    .sys_clk (sys_clk),
    .reset   (reset),
    .phase   (phase)
  );

  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  // opcode match is shared by the datapath and the checks
  function automatic logic isBz(input logic [15:0] w);
    return w[15:8] == BZ_OPCODE_HI;
  endfunction

  // n counts words, so the byte displacement is 2n with its sign kept
  function automatic logic [PC_WIDTH-1:0] byteDisp(input logic [7:0] n);
    return {{(PC_WIDTH-9){n[7]}}, n, 1'b0};
  endfunction

  // fixed step of one instruction word, widened to pc width
  function automatic logic [PC_WIDTH-1:0] stepExt();
    return {{(PC_WIDTH-2){1'b0}}, PC_STEP};
  endfunction

  // ----------------------------------------
  // instruction state
  // ----------------------------------------
  logic                active;
  logic                taken;
  logic [7:0]          offset;
  logic [PC_WIDTH-1:0] target;
  pc_write_t           next_pcWrite;
  logic                next_active;
  logic                next_taken;
  logic [7:0]          next_offset;
  logic [PC_WIDTH-1:0] next_target;
  logic                next_nopCycle;
  logic [PC_WIDTH-1:0] dispSum;

  // ----------------------------------------
  // target datapath
  // ----------------------------------------
  // pc still points at this word, so one step is added; sum wraps at pc width
  always_comb begin
    dispSum = pcNow + stepExt() + byteDisp(offset);
  end

  // ----------------------------------------
  // instruction sequencing
  // ----------------------------------------
  // one case item per phase; a nop cycle refuses the fetch in q1
  always_comb begin
    next_active   = active;
    next_taken    = taken;
    next_offset   = offset;
    next_target   = target;
    next_nopCycle = nopCycle;
    next_pcWrite  = '{wr: 1'b0, value: pcWrite.value};
    case (phase)
      PH_Q1: begin
        if (nopCycle) begin
          next_active = 1'b0;
        end else begin
          next_active = fetch.valid && isBz(fetch.word);
          next_taken  = fetch.valid && isBz(fetch.word) && zeroFlag;
        end
      end
      PH_Q2: begin
        if (active) begin
          next_offset = fetch.word[7:0];
        end
      end
      PH_Q3: begin
        if (active && taken) begin
          next_target = dispSum;
        end
      end
      PH_Q4: begin
        if (active && taken && !nopCycle) begin
          next_pcWrite  = '{wr: 1'b1, value: target};
          next_nopCycle = 1'b1;
        end else begin
          next_nopCycle = 1'b0;
          next_taken    = 1'b0;
        end
      end
      default: begin
        next_active = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // instruction registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      active   <= 1'b0;
      taken    <= 1'b0;
      offset   <= 8'h00;
      target   <= '0;
      pcWrite  <= '0;
      nopCycle <= 1'b0;
    end else begin
      active   <= next_active;
      taken    <= next_taken;
      offset   <= next_offset;
      target   <= next_target;
      pcWrite  <= next_pcWrite;
      nopCycle <= next_nopCycle;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // status flags are never touched by this instruction
  assign flagsWrite = 1'b0;
  assign busy       = active || nopCycle;

  // ----------------------------------------
  // nop length monitor
  // ----------------------------------------
  // counts clocks of the nop cycle so a stretched or short nop shows up
  logic [2:0] nopCount;
  logic [2:0] next_nopCount;

  always_comb begin
    if (nopCycle) begin
      next_nopCount = nopCount + 3'h1;
    end else begin
      next_nopCount = 3'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nopCount <= 3'h0;
    end else begin
      nopCount <= next_nopCount;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_write_only_q1: assert property (@(posedge sys_clk) disable iff (reset)
    pcWrite.wr |-> phase == PH_Q1) else $error("pc write outside q4 edge");
  a_nop_follows: assert property (@(posedge sys_clk) disable iff (reset)
    pcWrite.wr |-> nopCycle ##4 !nopCycle) else $error("nop cycle length wrong");
  a_no_flags: assert property (@(posedge sys_clk) disable iff (reset)
    !flagsWrite) else $error("flags modified");
  a_target_math: assert property (@(posedge sys_clk) disable iff (reset)
    (phase == PH_Q3 && active && taken) |=> target == $past(dispSum))
    else $error("target wrong");
  a_zero_gate: assert property (@(posedge sys_clk) disable iff (reset)
    (phase == PH_Q1 && !nopCycle && !zeroFlag) |-> ##4 !pcWrite.wr)
    else $error("branch without zero");
  a_opcode_gate: assert property (@(posedge sys_clk) disable iff (reset)
    (phase == PH_Q1 && !nopCycle && !isBz(fetch.word)) |-> ##4 !pcWrite.wr)
    else $error("branch on wrong opcode");
  a_taken_writes: assert property (@(posedge sys_clk) disable iff (reset)
    (phase == PH_Q1 && !nopCycle && fetch.valid && isBz(fetch.word) && zeroFlag)
    |-> ##4 pcWrite.wr) else $error("taken branch missed");
  a_nop_quiet: assert property (@(posedge sys_clk) disable iff (reset)
    nopCycle |-> !pcWrite.wr || phase == PH_Q1) else $error("write during nop");

  // ----------------------------------------
  // checks on timing and datapath
  // ----------------------------------------
  a_wr_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    pcWrite.wr |=> !pcWrite.wr) else $error("pc write longer than one clock");
  a_write_value: assert property (@(posedge sys_clk) disable iff (reset)
    pcWrite.wr |-> pcWrite.value == $past(target)) else $error("pc value wrong");
  a_offset_latch: assert property (@(posedge sys_clk) disable iff (reset)
    (phase == PH_Q2 && active) |=> offset == $past(fetch.word[7:0]))
    else $error("offset not read in q2");
  a_nop_refuse: assert property (@(posedge sys_clk) disable iff (reset)
    (phase == PH_Q1 && nopCycle) |=> !active) else $error("fetch taken in nop");
  a_phase_wrap: assert property (@(posedge sys_clk) disable iff (reset)
    phase == PH_Q4 |=> phase == PH_Q1) else $error("phase order wrong");
  a_not_taken_one: assert property (@(posedge sys_clk) disable iff (reset)
    (phase == PH_Q4 && active && !taken) |=> !nopCycle)
    else $error("nop after not taken");
  a_nop_max: assert property (@(posedge sys_clk) disable iff (reset)
    nopCycle |-> nopCount < NOP_CLOCKS) else $error("nop cycle too long");
  a_nop_length: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(nopCycle) |-> nopCount == NOP_CLOCKS) else $error("nop cycle too short");
  a_busy_nop: assert property (@(posedge sys_clk) disable iff (reset)
    pcWrite.wr |-> busy) else $error("idle during taken branch");
endmodule // branch_if_zero_exec

// ==== testbench/test_branch_if_zero_exec.sv ====
`timescale 1ns/100ps
module test_branch_if_zero_exec;
  import bz_pkg::*;
  logic                sys_clk;
  logic                reset;
  fetch_t              fetch;
  logic                zeroFlag;
  logic [PC_WIDTH-1:0] pcNow;
  phase_t              phase;
  pc_write_t           pcWrite;
  logic                nopCycle;
  logic                flagsWrite;
  logic                busy;
  int                  num_errors = 0;
  int                  samples_checked = 0;
  phase_t              order [4] = '{PH_Q2, PH_Q3, PH_Q4, PH_Q1};

  branch_if_zero_exec i_branch_if_zero_exec (
    .sys_clk(sys_clk), .reset(reset), .fetch(fetch), .zeroFlag(zeroFlag), .pcNow(pcNow),
    .phase(phase), .pcWrite(pcWrite), .nopCycle(nopCycle), .busy(busy),
    .flagsWrite(flagsWrite));

  // --------------------------------
  // compares and closing
  // --------------------------------
  task automatic check_val(input logic [PC_WIDTH-1:0] got, input logic [PC_WIDTH-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // --------------------------------
  // one instruction, eight clocks
  // --------------------------------
  // fetch held valid through the nop cycle: busy still high at the last clock means it was not refused
  task automatic run_one(input logic [15:0] w, input logic z, input logic [PC_WIDTH-1:0] pc,
                         input logic take);
    logic [PC_WIDTH-1:0] target;
    logic                bz;
    target = pc + PC_WIDTH'(PC_STEP) + {{(PC_WIDTH-9){w[7]}}, w[7:0], 1'b0};
    bz = (w[15:8] == BZ_OPCODE_HI);
    // phase read at the falling edge, where it is settled
    do @(negedge sys_clk); while (phase !== PH_Q4);
    @(posedge sys_clk);
    fetch <= '{valid: 1'b1, word: w};
    zeroFlag <= z;
    pcNow <= pc;
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      if ((i == 3 && !take) || i == 7) fetch.valid <= 1'b0;
      #1;
      check_val(PC_WIDTH'(phase), PC_WIDTH'(order[i%4]));
      check_val(PC_WIDTH'(pcWrite.wr), PC_WIDTH'(take && i == 3));
      check_val(PC_WIDTH'(nopCycle), PC_WIDTH'(take && i >= 3 && i < 7));
      check_val(PC_WIDTH'(flagsWrite), '0);
      check_val(PC_WIDTH'(busy), PC_WIDTH'(bz && (i < (take ? 7 : 4))));
      if (take && i == 3) check_val(pcWrite.value, target);
    end
  endtask

  task automatic t_forward;
    run_one(16'he07f, 1'b1, 21'h001000, 1'b1);
  endtask

  task automatic t_backward_wrap;
    run_one(16'he080, 1'b1, 21'h000010, 1'b1);
  endtask

  task automatic t_not_taken;
    run_one(16'he005, 1'b0, 21'h000400, 1'b0);
  endtask

  task automatic t_other_opcode;
    run_one(16'he105, 1'b1, 21'h000400, 1'b0);
  endtask

  // --------------------------------
  // clock, reset, sequence
  // --------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    reset = 1'b1;
    fetch = '0;
    zeroFlag = 1'b0;
    pcNow = '0;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    check_val(PC_WIDTH'(phase), PC_WIDTH'(PH_Q1));
    check_val(PC_WIDTH'(pcWrite.wr), '0);
    check_val(PC_WIDTH'(nopCycle), '0);
    t_forward();
    t_backward_wrap();
    t_not_taken();
    t_other_opcode();
    finish_test();
  end

  initial begin
    #20000;
    num_errors++;
    finish_test();
  end
endmodule // test_branch_if_zero_exec
